// file: rtl/conv_mode_switch.v
// Command interpreter for one-shot and continuous conversion switching.
`timescale 1ns/1ps
`include "conv_seq_defs.vh"
// Contract
// - The device acknowledges its address byte and every command or data byte it receives in a write.
// - Commands arrive in write transactions opened by start or repeated start with direction bit 0.
// - Pointer ACh selects the configuration upper byte and a data write there updates its SRAM shadow only.
// - A configuration upper byte with LSB zero selects continuous conversion mode.
// - Command 51h is acknowledged and starts temperature conversions.
// - Command 22h halts continuous conversion.
// - Command 48h copies the SRAM shadow into EEPROM.
// - A stop ends the exchange, or a repeated start continues it.
module conv_mode_switch #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
	parameter integer COPY_CYCLES = `COPY_CYCLES
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	output reg [7:0] cfg_shadow_o,
	output reg [7:0] cfg_eeprom_o,
	output reg single_conversion_select_o,
	output reg converting_o,
	output reg nonvolatile_busy_flag_o
);
	// ****************************************
	// Byte receiver
	// ****************************************
	wire oe_w;
	wire start_w;
	wire stop_w;
	wire bvalid_w;
	wire [7:0] byte_w;
	wire first_w;
	serial_byte_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe_o(oe_w),
		.start_o(start_w),
		.stop_o(stop_w),
		.byte_valid_o(bvalid_w),
		.byte_o(byte_w),
		.first_o(first_w)
	);

	// ****************************************
	// Transaction state
	// ****************************************
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_CMD = 4'b0010;
	localparam [3:0] ST_DATA = 4'b0100;
	localparam [3:0] ST_SKIP = 4'b1000;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [31:0] copy_cnt_r;
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (bvalid_w && first_w) begin
				state_nxt = ST_CMD;
			end
		end
		ST_CMD: begin
			if (bvalid_w && byte_w == `CFG_UPPER_PTR) begin
				state_nxt = ST_DATA;
			end else if (bvalid_w) begin
				state_nxt = ST_SKIP;
			end
		end
		ST_DATA: begin
			if (bvalid_w) begin
				state_nxt = ST_SKIP;
			end
		end
		// Bytes past the end of a command are acknowledged but have no
		// effect; the next command needs a repeated start.
		ST_SKIP: begin
			state_nxt = ST_SKIP;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
		// A new start or stop always resynchronises the interpreter.
		if (start_w || stop_w) begin
			state_nxt = ST_IDLE;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Byte classification
	// ****************************************
	wire cmd_byte_w;
	wire data_byte_w;
	wire conv_go_w;
	wire conv_halt_w;
	wire copy_go_w;
	// Only the byte right after the address is a command; after pointer ACh the next
	// byte is data for the shadow, and any other later byte is acknowledged and dropped.
	assign cmd_byte_w = bvalid_w & (state_r == ST_CMD);
	assign data_byte_w = bvalid_w & ~first_w &
		(state_r == ST_DATA);
	assign conv_go_w = cmd_byte_w &
		(byte_w == `CMD_START_CONV);
	assign conv_halt_w = cmd_byte_w &
		(byte_w == `CMD_STOP_CONV);
	assign copy_go_w = cmd_byte_w &
		(byte_w == `CMD_COPY_DATA);

	// ****************************************
	// Bus pin drive
	// ****************************************
	// Open drain: only the enable moves, the driven level is always
	// low.
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			sda_oe_o <= oe_w;
		end
	end

	// ****************************************
	// Configuration shadow
	// ****************************************
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			cfg_shadow_o <= `CFG_UPPER_RESET;
			single_conversion_select_o <= 1'b0;
		end else if (data_byte_w) begin
			cfg_shadow_o <= byte_w;
			// Mode follows the shadow; the EEPROM copy keeps the
			// power-up default until a copy command.
			single_conversion_select_o <=
				byte_w[`SINGLE_CONV_BIT];
		end
	end

	// ****************************************
	// Conversion control
	// ****************************************
	// The converter sits outside this block; this is only its run request.
	reg converting_nxt;
	always @* begin
		converting_nxt = converting_o;
		if (conv_go_w) begin
			converting_nxt = 1'b1;
		end
		if (conv_halt_w) begin
			converting_nxt = 1'b0;
		end
	end
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			converting_o <= 1'b0;
		end else begin
			converting_o <= converting_nxt;
		end
	end

	// ****************************************
	// Nonvolatile copy
	// ****************************************
	// The stored copy changes at once; busy stands for the write time.
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			cfg_eeprom_o <= `CFG_UPPER_RESET;
		end else if (copy_go_w) begin
			cfg_eeprom_o <= cfg_shadow_o;
		end
	end

	// ****************************************
	// Copy timer
	// ****************************************
	// Busy lets the master poll instead of waiting blind. A copy command
	// reloads the timer, so it wins over the count running out in the
	// same cycle.
	localparam [31:0] COPY_LOAD = COPY_CYCLES;
	reg [31:0] copy_cnt_nxt;
	always @* begin
		copy_cnt_nxt = copy_cnt_r;
		if (copy_cnt_r != 32'h00000000) begin
			copy_cnt_nxt = copy_cnt_r - 32'h00000001;
		end
		if (copy_go_w) begin
			copy_cnt_nxt = COPY_LOAD;
		end
	end
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			copy_cnt_r <= 32'h00000000;
			nonvolatile_busy_flag_o <= 1'b0;
		end else begin
			copy_cnt_r <= copy_cnt_nxt;
			nonvolatile_busy_flag_o <=
				(copy_cnt_nxt != 32'h00000000);
		end
	end
endmodule // conv_mode_switch

// file: rtl/conv_seq_defs.vh
// Constants for the conversion mode switch sequencer.
`ifndef CONV_SEQ_DEFS_VH
`define CONV_SEQ_DEFS_VH
`define CFG_UPPER_PTR 8'hAC
`define CMD_START_CONV 8'h51
`define CMD_STOP_CONV 8'h22
`define CMD_COPY_DATA 8'h48
`define SINGLE_CONV_BIT 0
`define CFG_UPPER_RESET 8'h00
`define DEV_ADDR_DEFAULT 7'h48
`define COPY_TIME_US 10000
`define CLK_MHZ 250
`define COPY_CYCLES (`COPY_TIME_US * `CLK_MHZ)
`endif

// file: rtl/serial_byte_slave.v
// Byte-level 2-wire slave: start/stop detect, shift-in, acknowledge drive.
`timescale 1ns/1ps
`include "conv_seq_defs.vh"
module serial_byte_slave #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_oe_o,
	output reg start_o,
	output reg stop_o,
	output reg byte_valid_o,
	output reg [7:0] byte_o,
	output reg first_o
);
	reg scl_q;
	reg sda_q;
	reg active_r;
	reg first_r;
	reg [3:0] bit_cnt_r;
	reg [7:0] shift_r;
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	wire start_det = scl_i & scl_q & sda_q & ~sda_i;
	wire stop_det = scl_i & scl_q & ~sda_q & sda_i;
	always @(posedge clk_i) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		start_o <= 1'b0;
		stop_o <= 1'b0;
		byte_valid_o <= 1'b0;
		if (!reset_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_oe_o <= 1'b0;
			byte_o <= 8'h00;
			first_o <= 1'b0;
			active_r <= 1'b0;
			first_r <= 1'b0;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
		end else if (start_det) begin
			start_o <= 1'b1;
			active_r <= 1'b1;
			first_r <= 1'b1;
			bit_cnt_r <= 4'h0;
			sda_oe_o <= 1'b0;
		end else if (stop_det) begin
			stop_o <= 1'b1;
			active_r <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (active_r) begin
			if (scl_rise && bit_cnt_r < 4'h8) begin
				shift_r <= {shift_r[6:0], sda_i};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (scl_fall && bit_cnt_r == 4'h8) begin
				// Address must match with write direction; reads are not
				// handled here so the slave withdraws from them.
				if (first_r && shift_r != {DEV_ADDR, 1'b0}) begin
					active_r <= 1'b0;
				end else begin
					sda_oe_o <= 1'b1;
					byte_valid_o <= 1'b1;
					byte_o <= shift_r;
					first_o <= first_r;
				end
				first_r <= 1'b0;
				bit_cnt_r <= 4'h9;
			end else if (scl_fall && bit_cnt_r == 4'h9) begin
				sda_oe_o <= 1'b0;
				bit_cnt_r <= 4'h0;
			end
		end
	end
endmodule // serial_byte_slave

// file: dv/bus_master_model.sv
// Behavioural 2-wire bus master for the sequencer.
`timescale 1ns/1ps
module bus_master_model(input wire clk_i, input wire sda_oe_i,
	output logic scl_o = 1, output logic sda_o = 1);
	task automatic hp;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic start;
		hp; sda_o <= 1; hp; scl_o <= 1; hp; sda_o <= 0; hp; scl_o <= 0;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			hp; sda_o <= b[i]; hp; scl_o <= 1; hp; scl_o <= 0;
		end
		hp; sda_o <= 1; hp; scl_o <= 1; ack = sda_oe_i; hp; scl_o <= 0;
	endtask
	task automatic stop;
		hp; sda_o <= 0; hp; scl_o <= 1; hp; sda_o <= 1;
	endtask
endmodule // bus_master_model

// file: dv/conv_mode_switch_assertions.sv
// Port checks for the conversion mode switch sequencer.
`timescale 1ns/1ps
module conv_mode_switch_assertions #(parameter integer COPY_CYCLES = 20) (
	input wire clk_i, reset_n_i, scl_i, sda_i, sda_o, sda_oe_o,
	input wire [7:0] cfg_shadow_o, cfg_eeprom_o,
	input wire single_conversion_select_o, converting_o,
	input wire nonvolatile_busy_flag_o);
	localparam int CMAX = COPY_CYCLES + 4;
	wire busy = nonvolatile_busy_flag_o;
	wire oe = sda_oe_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	ack_edge_a: assert property ($changed(oe) |-> !scl_i)
		else $error("ack edge in high");
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("sda high");
	ack_hold_a: assert property ($rose(scl_i) && $past(oe) |-> oe)
		else $error("ack lost");
	mode_bit_a: assert property (single_conversion_select_o ==
		cfg_shadow_o[0]) else $error("mode bit");
	copy_val_a: assert property ($rose(busy) |->
		##[0:1] cfg_eeprom_o == cfg_shadow_o) else $error("copy value");
	eeprom_only_a: assert property ($changed(cfg_eeprom_o) |->
		##[0:1] busy) else $error("eeprom write");
	busy_min_a: assert property ($rose(busy) |-> busy[*8])
		else $error("busy short");
	busy_max_a: assert property ($rose(busy) |-> ##[1:CMAX] !busy)
		else $error("busy long");
	cover property ($rose(converting_o));
	shadow_ack_a: assert property ($changed(cfg_shadow_o) |-> oe)
		else $error("shadow write outside ack");
	cmd_ack_a: assert property ($changed(converting_o) |-> oe)
		else $error("command outside ack");
	copy_ack_a: assert property ($rose(busy) |-> oe)
		else $error("copy outside ack");
	halt_idle_a: assert property ($fell(converting_o) |->
		!$past(busy)) else $error("halt during copy");
	cover property ($fell(converting_o));
	cover property ($rose(busy));
	cover property ($rose(single_conversion_select_o));
endmodule // conv_mode_switch_assertions
bind conv_mode_switch conv_mode_switch_assertions
	#(.COPY_CYCLES(COPY_CYCLES)) chk_u(
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.cfg_shadow_o(cfg_shadow_o),
	.cfg_eeprom_o(cfg_eeprom_o),
	.single_conversion_select_o(single_conversion_select_o),
	.converting_o(converting_o),
	.nonvolatile_busy_flag_o(nonvolatile_busy_flag_o));

// file: dv/conv_mode_switch_tb_top.sv
// Testbench for the conversion mode switch sequencer.
`timescale 1ns/1ps
module conv_mode_switch_tb_top;
	localparam [6:0] ADR = 7'h48;
	logic clk_i = 0, reset_n_i = 0, scl, sdm, oe, sdo, sc, conv, busy, a;
	logic [7:0] shadow, eeprom;
	int mismatches = 0, tests_run = 0;
	always #2 clk_i = ~clk_i;
	bus_master_model m_u(.clk_i(clk_i), .sda_oe_i(oe), .scl_o(scl),
		.sda_o(sdm));
	conv_mode_switch #(.DEV_ADDR(ADR), .COPY_CYCLES(40)) dut_u(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sdm & ~oe),
		.sda_o(sdo), .sda_oe_o(oe), .cfg_shadow_o(shadow),
		.cfg_eeprom_o(eeprom), .single_conversion_select_o(sc),
		.converting_o(conv), .nonvolatile_busy_flag_o(busy));
	task automatic chk(input logic [7:0] g, e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tx(input logic [7:0] c, d, input bit two);
		m_u.start;
		m_u.wr({ADR, 1'b0}, a); chk(8'(a), 1);
		m_u.wr(c, a); chk(8'(a), 1);
		if (two) begin m_u.wr(d, a); chk(8'(a), 1); end
		@(negedge clk_i);
	endtask
	task automatic wait_idle;
		int n = 0;
		while (busy !== 1'b0 && n < 100) begin @(negedge clk_i); n++; end
		if (busy !== 1'b0) begin mismatches++; results; end
	endtask
	task automatic results;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic t_to_single;
		tx(8'h51, 0, 0); chk(8'(conv), 1);
		chk(8'(sdo), 0);
		tx(8'hAC, 8'h01, 1); chk(8'(sc), 1); chk(eeprom, 0);
		tx(8'h48, 0, 0); chk(8'(busy), 1);
		wait_idle; chk(eeprom, 8'h01);
		tx(8'h22, 0, 0); m_u.stop; chk(8'(conv), 0);
	endtask
	task automatic t_to_cont;
		tx(8'hAC, 8'hFE, 1); chk(8'(sc), 0); chk(shadow, 8'hFE);
		tx(8'h51, 0, 0); tx(8'h48, 0, 0); m_u.stop;
		wait_idle; chk(eeprom, 8'hFE); chk(8'(conv), 1);
	endtask
	task automatic t_refuse;
		for (int i = 0; i < 2; i++) begin
			m_u.start; m_u.wr(i ? {ADR + 7'h01, 1'b0} : {ADR, 1'b1}, a);
			chk(8'(a), 0);
			m_u.wr(8'h22, a);
		end
		m_u.stop; @(negedge clk_i); chk(8'(conv), 1);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1;
		repeat (4) @(posedge clk_i);
		t_to_single;
		t_to_cont;
		t_refuse;
		results;
	end
endmodule // conv_mode_switch_tb_top
